/* File: rx_cfg_bank.sv */
// receive path configuration registers with their steering logic
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - usage 00 stronger channel, 01 stronger frozen per exchange, 10 both, 11 reserved
// - automatic usage codes act only while fixed channel bit is zero
// - fixed channel bit one: usage low bit picks I (X0) or Q (X1)
// - even select zero: tick rate is clock over 2v+1
// - even select one: tick rate is clock over 2v+2
// - receive time constant 00 freezes the loop through data reception
// - burst time constant field sets loop time constant during burst
// - preamble is B2 4D after zero to three leading 00 bytes
// - packet accepted only if length at least four times minimum field
// - at 106 kbit with sync detect off the minimum check is skipped
module rx_cfg_bank (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rx_cfg_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // demodulator channel levels
  input wire logic [7:0] i_level,
  input wire logic [7:0] q_level,
  input wire logic exchange_active,
  // channel choice
  output logic use_i,
  output logic use_q,
  // loop phases and control
  input wire logic burst_phase,
  input wire logic rx_phase,
  output var rx_cfg_pkg::loop_ctrl_t loop_ctrl,
  // timer
  output logic timer_tick,
  // sync preamble
  input wire logic preamble_start,
  output logic [7:0] preamble_byte,
  output logic preamble_valid,
  output logic preamble_done,
  // packet length check
  input wire rx_cfg_pkg::pkt_report_t pkt_report,
  input wire logic sync_detect_enable,
  output logic pkt_accept,
  output logic pkt_discard
);
  import rx_cfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode

  demod_cfg_t demod_cfg;
  sync_min_cfg_t sync_min_cfg;
  logic [DIV_W-1:0] timer_div;
  logic setup;
  logic word_ok;
  logic hit_demod;
  logic hit_sync;
  logic hit_div;
  logic mapped;
  logic wr_fire;

  assign setup = psel && !penable;
  assign word_ok = paddr[1:0] == 2'h0 && paddr[ADDR_W-1:10] == '0;
  assign hit_demod = word_ok && paddr[9:2] == DEMOD_CFG_IDX;
  assign hit_sync = word_ok && paddr[9:2] == SYNC_MIN_IDX;
  assign hit_div = word_ok && paddr[9:2] == TIMER_DIV_IDX;
  assign mapped = hit_demod || hit_sync || hit_div;
  // zero wait states keeps host polling simple
  assign pready = 1'b1;
  assign wr_fire = psel && penable && pwrite && mapped;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pslverr <= 1'b0;
    end else if (setup) begin
      pslverr <= !mapped;
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      demod_cfg <= DEMOD_CFG_RESET;
    end else if (wr_fire && hit_demod) begin
      demod_cfg <= pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync_min_cfg <= SYNC_MIN_RESET;
    end else if (wr_fire && hit_sync) begin
      sync_min_cfg <= pwdata[7:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      timer_div <= TIMER_DIV_RESET;
    end else if (wr_fire && hit_div) begin
      timer_div <= pwdata[DIV_W-1:0];
    end
  end

  // read data prepared in setup, valid through the access phase
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      if (hit_demod) begin
        prdata <= {24'h000000, demod_cfg};
      end else if (hit_sync) begin
        prdata <= {24'h000000, sync_min_cfg};
      end else if (hit_div) begin
        prdata <= {{(32 - DIV_W){1'b0}}, timer_div};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // channel choice

  logic i_stronger;
  logic exch_prev;
  logic frozen_i;
  logic next_use_i;
  logic next_use_q;

  assign i_stronger = i_level >= q_level;

  // choice taken at exchange start and held until it ends
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      exch_prev <= 1'b0;
      frozen_i <= 1'b1;
    end else begin
      exch_prev <= exchange_active;
      if (!exchange_active || !exch_prev) begin
        frozen_i <= i_stronger;
      end
    end
  end

  always_comb begin
    next_use_i = i_stronger;
    next_use_q = !i_stronger;
    if (demod_cfg.fixed_channel_enable) begin
      next_use_i = !demod_cfg.channel_usage_select[0];
      next_use_q = demod_cfg.channel_usage_select[0];
    end else begin
      case (demod_cfg.channel_usage_select)
        USAGE_STRONGER: begin
          next_use_i = i_stronger;
          next_use_q = !i_stronger;
        end
        USAGE_FROZEN: begin
          if (exchange_active && exch_prev) begin
            next_use_i = frozen_i;
            next_use_q = !frozen_i;
          end
        end
        USAGE_COMBINED: begin
          next_use_i = 1'b1;
          next_use_q = 1'b1;
        end
        // reserved code behaves as the stronger channel
        default: begin
          next_use_i = i_stronger;
          next_use_q = !i_stronger;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      use_i <= 1'b1;
      use_q <= 1'b0;
    end else begin
      use_i <= next_use_i;
      use_q <= next_use_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // loop control

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      loop_ctrl <= '0;
    end else if (rx_phase) begin
      loop_ctrl.freeze <= demod_cfg.receive_loop_time_const == LOOP_TC_FROZEN;
      loop_ctrl.time_const <= demod_cfg.receive_loop_time_const;
    end else if (burst_phase) begin
      loop_ctrl.freeze <= 1'b0;
      loop_ctrl.time_const <= demod_cfg.burst_loop_time_const;
    end else begin
      // between phases the loop runs free on the last constant
      loop_ctrl.freeze <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // timer and preamble

  timer_prescaler u_timer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .div_value(timer_div),
    .even_sel(demod_cfg.timer_divider_even_select),
    .tick(timer_tick)
  );

  sync_preamble_gen u_preamble (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .start(preamble_start),
    .pad_count(sync_min_cfg.sync_preamble_length),
    .byte_data(preamble_byte),
    .byte_valid(preamble_valid),
    .done(preamble_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // packet length check

  logic [8:0] min_len;
  logic skip_check;
  logic long_enough;

  assign min_len = {1'b0, sync_min_cfg.min_packet_length_quads, 2'b00};
  assign skip_check = pkt_report.rate_106 && !sync_detect_enable;
  assign long_enough = pkt_report.length >= min_len;

  // short packets are dropped without any error flag
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pkt_accept <= 1'b0;
      pkt_discard <= 1'b0;
    end else begin
      pkt_accept <= pkt_report.done && (skip_check || long_enough);
      pkt_discard <= pkt_report.done && !skip_check && !long_enough;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  property p_combined;
    @(posedge core_clk) disable iff (sys_rst)
      (!demod_cfg.fixed_channel_enable && demod_cfg.channel_usage_select == USAGE_COMBINED)
        |=> use_i && use_q;
  endproperty
  a_combined: assert property (p_combined) else $error("combine not applied");
  property p_frozen_hold;
    @(posedge core_clk) disable iff (sys_rst)
      (!demod_cfg.fixed_channel_enable && demod_cfg.channel_usage_select == USAGE_FROZEN
        && exchange_active && $past(exchange_active) && $stable(demod_cfg))
        |=> $stable(use_i);
  endproperty
  a_frozen_hold: assert property (p_frozen_hold) else $error("frozen choice moved");
  property p_fixed_over_auto;
    @(posedge core_clk) disable iff (sys_rst)
      demod_cfg.fixed_channel_enable
        |=> (use_i != use_q) || !$past(demod_cfg.fixed_channel_enable);
  endproperty
  a_fixed_over_auto: assert property (p_fixed_over_auto) else $error("fixed not single");
  property p_fixed_pick;
    @(posedge core_clk) disable iff (sys_rst)
      demod_cfg.fixed_channel_enable ##1 $stable(demod_cfg)
        |-> use_q == demod_cfg.channel_usage_select[0];
  endproperty
  a_fixed_pick: assert property (p_fixed_pick) else $error("fixed channel wrong");
  property p_rx_freeze;
    @(posedge core_clk) disable iff (sys_rst)
      (rx_phase && demod_cfg.receive_loop_time_const == LOOP_TC_FROZEN) |=> loop_ctrl.freeze;
  endproperty
  a_rx_freeze: assert property (p_rx_freeze) else $error("loop not frozen");
  property p_burst_tc;
    @(posedge core_clk) disable iff (sys_rst)
      (!rx_phase && burst_phase)
        |=> !loop_ctrl.freeze && loop_ctrl.time_const == $past(demod_cfg.burst_loop_time_const);
  endproperty
  a_burst_tc: assert property (p_burst_tc) else $error("burst constant wrong");
  property p_short_drop;
    @(posedge core_clk) disable iff (sys_rst)
      (pkt_report.done && !skip_check && pkt_report.length < min_len)
        |=> pkt_discard && !pkt_accept;
  endproperty
  a_short_drop: assert property (p_short_drop) else $error("short packet kept");
  property p_skip_106;
    @(posedge core_clk) disable iff (sys_rst)
      (pkt_report.done && pkt_report.rate_106 && !sync_detect_enable) |=> pkt_accept;
  endproperty
  a_skip_106: assert property (p_skip_106) else $error("check not skipped");
  property p_readback;
    @(posedge core_clk) disable iff (sys_rst)
      (wr_fire && hit_demod) ##1 !psel ##1 (setup && !pwrite && hit_demod)
        |=> prdata[7:0] == $past(pwdata[7:0], 3);
  endproperty
  a_readback: assert property (p_readback) else $error("readback mismatch");
  c_combined: cover property (@(posedge core_clk) use_i && use_q);
  c_discard: cover property (@(posedge core_clk) pkt_discard);
  c_freeze: cover property (@(posedge core_clk) loop_ctrl.freeze);
endmodule
`default_nettype wire

/* File: rx_cfg_pkg.sv */
// shared constants and carriers for the receive configuration bank
package rx_cfg_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] DEMOD_CFG_IDX = 8'h19;
  localparam logic [7:0] SYNC_MIN_IDX = 8'h1A;
  localparam logic [7:0] TIMER_DIV_IDX = 8'h30;
  localparam int ADDR_W = 12;
  localparam int DIV_W = 12;
  localparam logic [7:0] DEMOD_CFG_RESET = 8'h4D;
  localparam logic [7:0] SYNC_MIN_RESET = 8'h00;
  localparam logic [DIV_W-1:0] TIMER_DIV_RESET = 12'h000;
  // channel usage codes
  localparam logic [1:0] USAGE_STRONGER = 2'h0;
  localparam logic [1:0] USAGE_FROZEN = 2'h1;
  localparam logic [1:0] USAGE_COMBINED = 2'h2;
  localparam logic [1:0] LOOP_TC_FROZEN = 2'h0;
  // preamble bytes
  localparam logic [7:0] PRE_PAD = 8'h00;
  localparam logic [7:0] PRE_FIRST = 8'hB2;
  localparam logic [7:0] PRE_SECOND = 8'h4D;
  localparam int PRE_BASE_LEN = 2;

  typedef struct packed {
    logic [1:0] channel_usage_select;
    logic fixed_channel_enable;
    logic timer_divider_even_select;
    logic [1:0] receive_loop_time_const;
    logic [1:0] burst_loop_time_const;
  } demod_cfg_t;

  typedef struct packed {
    logic [1:0] sync_preamble_length;
    logic [5:0] min_packet_length_quads;
  } sync_min_cfg_t;

  // one packet end report from the decoder
  typedef struct packed {
    logic done;
    logic [8:0] length;
    logic rate_106;
  } pkt_report_t;

  typedef struct packed {
    logic freeze;
    logic [1:0] time_const;
  } loop_ctrl_t;
endpackage

/* File: timer_prescaler.sv */
// timer tick divider with odd or even divide formula
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // configuration
  input wire logic [rx_cfg_pkg::DIV_W-1:0] div_value,
  input wire logic even_sel,
  // tick
  output logic tick
);
  import rx_cfg_pkg::*;

  logic [DIV_W:0] period;
  logic [DIV_W:0] count;

  // period is 2v+1, or 2v+2 with the even select
  assign period = {div_value, 1'b0} + {{DIV_W{1'b0}}, 1'b1} + {{DIV_W{1'b0}}, even_sel};

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      count <= '0;
      tick <= 1'b0;
    end else if (count >= period - 1'b1) begin
      count <= '0;
      tick <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick <= 1'b0;
    end
  end

  // helper: cycles since last tick, and whether that span ran on one steady period
  logic [DIV_W:0] gap;
  logic [DIV_W:0] period_q;
  logic seen;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      gap <= '0;
      period_q <= '0;
      seen <= 1'b0;
    end else begin
      gap <= tick ? {{DIV_W{1'b0}}, 1'b1} : gap + 1'b1;
      period_q <= period;
      // a period change voids the span in flight, so its end is not judged
      if (period != period_q) begin
        seen <= 1'b0;
      end else if (tick) begin
        seen <= 1'b1;
      end
    end
  end

  property p_tick_period;
    @(posedge core_clk) disable iff (sys_rst)
      (tick && seen && $stable(period) && $past(period) == period) |-> gap == period;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick spacing off");
  property p_even_longer;
    @(posedge core_clk) disable iff (sys_rst)
      even_sel |-> period == {div_value, 1'b0} + 2'd2;
  endproperty
  a_even_longer: assert property (p_even_longer) else $error("even period wrong");
  c_tick: cover property (@(posedge core_clk) tick && seen);
endmodule
`default_nettype wire

/* File: sync_preamble_gen.sv */
// emits the sync preamble byte by byte
`timescale 1ns/1ps
`default_nettype none
module sync_preamble_gen (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // control
  input wire logic start,
  input wire logic [1:0] pad_count,
  // byte stream
  output logic [7:0] byte_data,
  output logic byte_valid,
  output logic done
);
  import rx_cfg_pkg::*;

  logic busy;
  logic [2:0] idx;
  logic [1:0] pad_held;

  // pad count latched so a register write mid-preamble cannot tear it
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      busy <= 1'b0;
      idx <= '0;
      pad_held <= '0;
      byte_data <= PRE_PAD;
      byte_valid <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      byte_valid <= busy;
      if (!busy && start) begin
        busy <= 1'b1;
        idx <= '0;
        pad_held <= pad_count;
      end else if (busy) begin
        idx <= idx + 1'b1;
        if (idx < {1'b0, pad_held}) begin
          byte_data <= PRE_PAD;
        end else if (idx == {1'b0, pad_held}) begin
          byte_data <= PRE_FIRST;
        end else begin
          byte_data <= PRE_SECOND;
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

  property p_preamble_tail;
    @(posedge core_clk) disable iff (sys_rst)
      done |-> byte_data == PRE_SECOND && $past(byte_data) == PRE_FIRST;
  endproperty
  a_preamble_tail: assert property (p_preamble_tail) else $error("preamble tail wrong");
  property p_zero_pad;
    @(posedge core_clk) disable iff (sys_rst)
      (!busy && start && pad_count == 2'h0) |=> ##1 byte_data == PRE_FIRST ##1 done;
  endproperty
  a_zero_pad: assert property (p_zero_pad) else $error("short preamble wrong");
  c_long: cover property (@(posedge core_clk) done && pad_held == 2'h3);
endmodule
`default_nettype wire

/* File: rx_cfg_bank_tb.sv */
// self-checking bench for the receive configuration bank
`timescale 1ns/1ps
`default_nettype none
module rx_cfg_bank_tb;
  import rx_cfg_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] i_level = 8'h00;
  logic [7:0] q_level = 8'h00;
  logic exchange_active = 1'b0;
  logic use_i;
  logic use_q;
  logic burst_phase = 1'b0;
  logic rx_phase = 1'b0;
  loop_ctrl_t loop_ctrl;
  logic timer_tick;
  logic preamble_start = 1'b0;
  logic [7:0] preamble_byte;
  logic preamble_valid;
  logic preamble_done;
  pkt_report_t pkt_report = '0;
  logic sync_detect_enable = 1'b0;
  logic pkt_accept;
  logic pkt_discard;
  int errors = 0;
  int tests_run = 0;
  int seed = 8385;
  logic [31:0] rd;
  logic err;

  always #2.5 core_clk = ~core_clk;

  rx_cfg_bank dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .i_level(i_level), .q_level(q_level),
    .exchange_active(exchange_active), .use_i(use_i), .use_q(use_q),
    .burst_phase(burst_phase), .rx_phase(rx_phase), .loop_ctrl(loop_ctrl),
    .timer_tick(timer_tick), .preamble_start(preamble_start), .preamble_byte(preamble_byte),
    .preamble_valid(preamble_valid), .preamble_done(preamble_done), .pkt_report(pkt_report),
    .sync_detect_enable(sync_detect_enable), .pkt_accept(pkt_accept),
    .pkt_discard(pkt_discard));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks run %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // entered and left at a rising edge; one idle edge keeps strobes apart
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ADDR_W'({idx, 2'b00});
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    // wait for the answer however long it takes; the watchdog bounds a hang
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  function automatic logic [1:0] exp_sel(logic [1:0] u, logic f, logic [7:0] i, logic [7:0] q);
    if (f) return u[0] ? 2'b01 : 2'b10;
    if (u == USAGE_COMBINED) return 2'b11;
    return (i > q) ? 2'b10 : 2'b01;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    logic [5:0] m;
    logic [8:0] len;
    logic acc;
    int n;
    int p;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    apb(1'b0, DEMOD_CFG_IDX, 32'h0);
    check("demod reset", rd, 32'h0000004D);
    apb(1'b0, SYNC_MIN_IDX, 32'h0);
    check("sync reset", rd, 32'h00000000);
    apb(1'b0, 8'h01, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    // random write and read back, upper bits must read zero
    for (int k = 0; k < 6; k++) begin
      d = 8'($random(seed));
      apb(1'b1, k[0] ? SYNC_MIN_IDX : DEMOD_CFG_IDX, ({$random(seed)} & 32'hFFFFFF00) | 32'(d));
      apb(1'b0, k[0] ? SYNC_MIN_IDX : DEMOD_CFG_IDX, 32'h0);
      check("readback", rd, {24'h0, d});
    end
    // channel choice and loop control over every usage, fixed and receive constant code combination
    for (int k = 0; k < 32; k++) begin
      d = 8'($random(seed));
      d[7:5] = k[2:0];
      d[3:2] = k[4:3];
      apb(1'b1, DEMOD_CFG_IDX, {24'h0, d});
      i_level <= 8'($random(seed)) | 8'h01;
      q_level <= {k[0], 7'h00} ^ 8'h80;
      rx_phase <= k[1] ^ k[3];
      burst_phase <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      check("channel", {use_i, use_q}, exp_sel(d[7:6], d[5], i_level, q_level));
      if (rx_phase) begin
        check("freeze", loop_ctrl.freeze, d[3:2] == LOOP_TC_FROZEN);
        if (d[3:2] != LOOP_TC_FROZEN) check("rx tc", loop_ctrl.time_const, d[3:2]);
      end else begin
        check("burst tc", loop_ctrl, {1'b0, d[1:0]});
      end
      @(posedge core_clk);
    end
    // frozen choice holds through the exchange
    apb(1'b1, DEMOD_CFG_IDX, {24'h0, USAGE_FROZEN, 6'h00});
    i_level <= 8'hC0;
    q_level <= 8'h10;
    repeat (2) @(posedge core_clk);
    exchange_active <= 1'b1;
    repeat (2) @(posedge core_clk);
    i_level <= 8'h10;
    q_level <= 8'hC0;
    repeat (3) @(posedge core_clk);
    #1;
    check("frozen", {use_i, use_q}, 2'b10);
    @(posedge core_clk);
    exchange_active <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    check("unfrozen", {use_i, use_q}, 2'b01);
    // fixed first channel, as the host sets it for the secure element link
    @(posedge core_clk);
    apb(1'b1, DEMOD_CFG_IDX, {24'h0, 2'b00, 1'b1, 5'h00});
    repeat (2) @(posedge core_clk);
    #1;
    check("link channel", {use_i, use_q}, 2'b10);
    // timer tick period for both divide formulas
    for (int k = 0; k < 6; k++) begin
      @(posedge core_clk);
      apb(1'b1, TIMER_DIV_IDX, (k / 2) * 3);
      apb(1'b1, DEMOD_CFG_IDX, {27'h0, k[0], 4'h0});
      repeat (2) begin
        n = 0;
        do begin
          @(posedge core_clk);
          n++;
        end while (timer_tick !== 1'b1 && n < 100);
      end
      p = 0;
      do begin
        @(posedge core_clk);
        p++;
      end while (timer_tick !== 1'b1 && p < 100);
      check("tick period", p, 2 * ((k / 2) * 3) + 1 + k[0]);
    end
    // preamble for every length code
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, SYNC_MIN_IDX, {24'h0, k[1:0], 6'h00});
      preamble_start <= 1'b1;
      @(posedge core_clk);
      preamble_start <= 1'b0;
      n = 0;
      p = 0;
      while (p < 12) begin
        @(posedge core_clk);
        p++;
        if (preamble_valid === 1'b1) begin
          check("pre byte", preamble_byte,
                n < k ? PRE_PAD : (n == k ? PRE_FIRST : PRE_SECOND));
          n++;
          if (preamble_done === 1'b1) p = 12;
        end
      end
      check("pre count", n, k + PRE_BASE_LEN);
    end
    // minimum length with boundary lengths, rate and sync detect
    for (int k = 0; k < 24; k++) begin
      m = 6'($random(seed));
      len = (k % 3 == 0) ? 9'(4 * m) : (k % 3 == 1) ? 9'(4 * m - 1) : 9'($random(seed));
      apb(1'b1, SYNC_MIN_IDX, {24'h0, 2'h0, m});
      pkt_report <= '{1'b1, len, k[2]};
      sync_detect_enable <= k[3];
      @(posedge core_clk);
      pkt_report.done <= 1'b0;
      #1;
      acc = (k[2] && !k[3]) || (32'(len) >= 4 * m);
      check("accept", {pkt_accept, pkt_discard}, {acc, !acc});
      @(posedge core_clk);
    end
    @(posedge core_clk);
    report_and_stop();
  end

  initial begin
    #400000;
    errors++;
    report_and_stop();
  end
endmodule
`default_nettype wire
